// ===== bench/tb_timer_channel_status_flags.sv
// bench for the timer channel status flag block
`timescale 1ns/1ps
module tb_timer_channel_status_flags;
    logic                 hclk = 1'b0;
    logic                 hresetn = 1'b0;
    logic                 hsel = 1'b0;
    logic                 hwrite = 1'b0;
    logic [1:0]           htrans = 2'h0;
    logic [31:0]          haddr = '0;
    logic [31:0]          hwdata = '0;
    logic [31:0]          hrdata;
    logic [31:0]          rd;
    logic                 hreadyout;
    logic                 irq;
    logic [1:0]           hresp;
    logic [4:0]           ovf_req;
    logic [4:0]           unf_req;
    logic [4:0]           dm_req;
    tsf_pkg::chan_in_s [4:0] ci = '0;
    int                   fail_count = 0;
    int                   samples_checked = 0;
    logic [11:0] ra [9] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h10c,
                            12'h010, 12'h020, 12'h030, 12'h044};
    logic [7:0]  re [9] = '{8'hc0, 8'hc0, 8'h40, 8'hc0, 8'h00,
                            8'h40, 8'h00, 8'h00, 8'h00};
    always #2 hclk = ~hclk;
    timer_channel_status_flags uut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .chan_in(ci), .ovf_req(ovf_req), .unf_req(unf_req),
        .dmatch_req(dm_req), .irq(irq));
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            fail_count++;
            results;
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= tsf_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    initial begin
        cyc(6);
        hresetn <= 1'b1;
        ci[1].count_up <= 1'b1;
        ci[3].count_up <= 1'b1;
        ci[0].grd <= 16'h0005;
        cyc(1);
        for (int i = 0; i < 9; i++) rchk(ra[i], {24'h0, re[i]});
        bus(1'b1, 12'h030, 32'h10);
        bus(1'b1, 12'h044, 32'h2000);
        ci[4].counter <= 16'hffff;
        cyc(1);
        ci[4].counter <= 16'h0000;
        cyc(3);
        chk({27'h0, ovf_req}, 32'h10);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 12'h010, 32'hd0);
        bus(1'b1, 12'h010, 32'h40);
        rchk(12'h010, 32'h50);
        bus(1'b1, 12'h010, 32'h40);
        rchk(12'h010, 32'h40);
        chk({27'h0, ovf_req}, 32'h0);
        bus(1'b1, 12'h040, 32'h2000);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        ci[1].phase_mode <= 1'b1;
        ci[3].phase_mode <= 1'b1;
        ci[1].counter <= 16'hffff;
        ci[3].counter <= 16'hffff;
        ci[4].comp_pwm <= 1'b1;
        ci[4].counter <= 16'h0001;
        ci[0].d_compare <= 1'b1;
        ci[0].counter <= 16'h0005;
        cyc(1);
        ci[4].counter <= 16'h0000;
        cyc(2);
        rchk(12'h004, 32'he0);
        rchk(12'h00c, 32'hc0);
        rchk(12'h010, 32'h50);
        rchk(12'h000, 32'hc8);
        ci[4].xfer_ovf <= 1'b1;
        ci[0].xfer_d <= 1'b1;
        ci[3].d_capture <= 1'b1;
        ci[3].capture_stb <= 1'b1;
        cyc(1);
        ci[4].xfer_ovf <= 1'b0;
        ci[0].xfer_d <= 1'b0;
        ci[3].capture_stb <= 1'b0;
        cyc(2);
        rchk(12'h010, 32'h40);
        rchk(12'h000, 32'hc0);
        rchk(12'h00c, 32'hc8);
        ci[3].xfer_select <= 1'b1;
        ci[3].xfer_d <= 1'b1;
        ci[4].counter <= 16'h0001;
        cyc(1);
        ci[3].xfer_d <= 1'b0;
        ci[4].counter <= 16'h0000;
        ci[4].xfer_ovf <= 1'b1;
        cyc(1);
        ci[4].xfer_ovf <= 1'b0;
        cyc(1);
        rchk(12'h00c, 32'hc8);
        rchk(12'h010, 32'h50);
        bus(1'b1, 12'h024, 32'h20);
        bus(1'b1, 12'h02c, 32'h08);
        cyc(1);
        chk({27'h0, unf_req}, 32'h02);
        chk({27'h0, dm_req}, 32'h08);
        chk({30'h0, hresp}, 32'h0);
        hresetn <= 1'b0;
        cyc(2);
        chk(hrdata, 32'h0);
        chk({26'h0, irq, ovf_req}, 32'h0);
        hresetn <= 1'b1;
        cyc(1);
        rchk(12'h000, 32'hc0);
        rchk(12'h004, 32'hc0);
        results;
    end
endmodule // tb_timer_channel_status_flags

// ===== hdl/status_flag_cell.sv
// one event flag: set by hardware, cleared by read-one then write-zero
`timescale 1ns/1ps
module status_flag_cell (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // event side
    input  wire logic set_evt,
    input  wire logic auto_clr,
    // software side
    input  wire logic rd_seen,
    input  wire logic wr_seen,
    input  wire logic wr_bit,
    // flag
    output logic      flag
);

    logic flag_reg;
    logic flag_next;
    logic armed_reg;
    logic armed_next;
    wire  clr_sw;

    // ----------------------------------------------------------------
    // flag update
    // ----------------------------------------------------------------
    assign clr_sw     = wr_seen & ~wr_bit & armed_reg;
    assign flag_next  = set_evt ? 1'b1 :
                        (clr_sw | auto_clr) ? 1'b0 : flag_reg;
    assign armed_next = ~flag_next ? 1'b0 :
                        (rd_seen & flag_reg) ? 1'b1 :
                        wr_seen ? 1'b0 : armed_reg;
    assign flag       = flag_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_reg  <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            flag_reg  <= flag_next;
            armed_reg <= armed_next;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_clr_needs_read;
        @(posedge hclk) disable iff (!hresetn)
        (wr_seen && !wr_bit && !armed_reg && !set_evt && !auto_clr)
            |=> flag_reg == $past(flag_reg);
    endproperty
    a_clr_needs_read: assert property (p_clr_needs_read)
        else $error("flag cleared without prior read of one");

    property p_write_one_keeps;
        @(posedge hclk) disable iff (!hresetn)
        (wr_seen && wr_bit && !auto_clr) |=> flag_reg || !$past(flag_reg);
    endproperty
    a_write_one_keeps: assert property (p_write_one_keeps)
        else $error("writing one changed the flag");

    property p_set_wins;
        @(posedge hclk) disable iff (!hresetn)
        (set_evt && (clr_sw || auto_clr)) |=> flag_reg;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear won over a same-cycle set");

endmodule // status_flag_cell

// ===== hdl/timer_channel_status_flags.sv
// per-channel status flags of a five-channel 16-bit timer, ahb-lite slave
`timescale 1ns/1ps
module timer_channel_status_flags (
    // clock and reset
    input  wire logic                            hclk,
    input  wire logic                            hresetn,
    // ahb-lite slave
    input  wire logic                            hsel,
    input  wire logic [31:0]                     haddr,
    input  wire logic [1:0]                      htrans,
    input  wire logic                            hwrite,
    input  wire logic [2:0]                      hsize,
    input  wire logic [31:0]                     hwdata,
    input  wire logic                            hready,
    output logic      [31:0]                     hrdata,
    output logic                                 hreadyout,
    output logic      [1:0]                      hresp,
    // counter core
    input  wire tsf_pkg::chan_in_s [tsf_pkg::NCH-1:0] chan_in,
    // interrupt requests
    output logic      [tsf_pkg::NCH-1:0]         ovf_req,
    output logic      [tsf_pkg::NCH-1:0]         unf_req,
    output logic      [tsf_pkg::NCH-1:0]         dmatch_req,
    output logic                                 irq
);

    localparam int NCH = tsf_pkg::NCH;
    localparam int CW  = tsf_pkg::CW;

    // ----------------------------------------------------------------
    // bus state
    // ----------------------------------------------------------------
    tsf_pkg::bus_state_e     state_reg;
    tsf_pkg::bus_state_e     state_next;
    tsf_pkg::bus_req_s       req_reg;
    tsf_pkg::bus_req_s       req_next;
    logic [31:0]             hrdata_reg;
    logic                    hreadyout_reg;
    logic [1:0]              hresp_reg;
    wire                     take;
    wire                     in_data;
    wire                     wr_stb;
    wire                     rd_stb;
    wire                     sel_irq_stat;
    wire                     sel_irq_mask;
    wire [31:0]              rd_word;

    // ----------------------------------------------------------------
    // per-channel state
    // ----------------------------------------------------------------
    logic [CW-1:0]           prev_reg [NCH];
    logic                    prev_ok_reg;
    logic [tsf_pkg::EV_W-1:0] en_reg  [NCH];
    logic [NCH-1:0]          ovf_req_reg;
    logic [NCH-1:0]          unf_req_reg;
    logic [NCH-1:0]          dm_req_reg;
    wire  [NCH-1:0]          ovf_evt;
    wire  [NCH-1:0]          unf_evt;
    wire  [NCH-1:0]          dm_evt;
    wire  [NCH-1:0]          ovf_flag;
    wire  [NCH-1:0]          unf_flag;
    wire  [NCH-1:0]          dm_flag;
    wire  [NCH-1:0]          sel_stat;
    wire  [NCH-1:0]          sel_en;
    wire  [7:0]              stat_val [NCH];
    wire  [31:0]             rd_term  [NCH];

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    logic [tsf_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [tsf_pkg::IRQ_W-1:0] irq_stat_next;
    logic [tsf_pkg::IRQ_W-1:0] irq_mask_reg;
    logic                      irq_reg;
    wire  [tsf_pkg::IRQ_W-1:0] irq_evt;
    wire  [tsf_pkg::IRQ_W-1:0] irq_w1c;

    // ----------------------------------------------------------------
    // ahb-lite address and data phase
    // ----------------------------------------------------------------
    assign take    = (state_reg == tsf_pkg::BUS_IDLE) & hsel & hready &
                     (htrans == tsf_pkg::HTRANS_NONSEQ);
    assign in_data = state_reg == tsf_pkg::BUS_DATA;
    assign wr_stb  = in_data & req_reg.write & req_reg.in_range;
    assign rd_stb  = in_data & ~req_reg.write & req_reg.in_range;

    assign state_next = take ? tsf_pkg::BUS_DATA : tsf_pkg::BUS_IDLE;
    assign req_next   = take ? tsf_pkg::bus_req_s'{write: hwrite,
                                 in_range: haddr[31:tsf_pkg::AW] == 24'h0,
                                 addr:     haddr[tsf_pkg::AW-1:0]}
                             : req_reg;
    assign sel_irq_stat = req_reg.addr == tsf_pkg::IRQ_STATUS_OFS;
    assign sel_irq_mask = req_reg.addr == tsf_pkg::IRQ_MASK_OFS;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg     <= tsf_pkg::BUS_IDLE;
            req_reg       <= '0;
            hreadyout_reg <= 1'b1;
            hrdata_reg    <= 32'h0;
            hresp_reg     <= tsf_pkg::HRESP_OKAY;
        end else begin
            state_reg     <= state_next;
            req_reg       <= req_next;
            hreadyout_reg <= ~take;
            hrdata_reg    <= (in_data & ~req_reg.write) ? rd_word : hrdata_reg;
            hresp_reg     <= tsf_pkg::HRESP_OKAY;
        end
    end

    // ----------------------------------------------------------------
    // channel slices
    // ----------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            wire [CW-1:0] cur;
            wire          dir_bit;
            wire          pwm_wrap;
            wire          ovf_auto;
            wire          dm_auto;
            assign cur = chan_in[ch].counter;
            assign sel_stat[ch] = req_reg.addr ==
                8'(tsf_pkg::STATUS_BASE + tsf_pkg::WORD_STEP * ch);
            assign sel_en[ch] = req_reg.addr ==
                8'(tsf_pkg::ENABLE_BASE + tsf_pkg::WORD_STEP * ch);

            // wrap, compare match and capture detection
            assign pwm_wrap = (ch == tsf_pkg::PWM_CH) &
                chan_in[ch].comp_pwm & (prev_reg[ch] == tsf_pkg::CNT_ONE) &
                (cur == tsf_pkg::CNT_ZERO);
            assign ovf_evt[ch] = prev_ok_reg & (pwm_wrap |
                ((prev_reg[ch] == tsf_pkg::CNT_MAX) &
                 (cur == tsf_pkg::CNT_ZERO)));
            assign unf_evt[ch] = tsf_pkg::UNF_CH[ch] & prev_ok_reg &
                chan_in[ch].phase_mode &
                (prev_reg[ch] == tsf_pkg::CNT_ZERO) &
                (cur == tsf_pkg::CNT_MAX);
            assign dm_evt[ch] = tsf_pkg::DFL_CH[ch] &
                ((chan_in[ch].d_compare & (cur == chan_in[ch].grd) &
                  (cur != prev_reg[ch]) & prev_ok_reg) |
                 (chan_in[ch].d_capture & chan_in[ch].capture_stb));

            // transfer controller auto clear
            assign ovf_auto = (ch == tsf_pkg::PWM_CH) &
                chan_in[ch].xfer_ovf & ~chan_in[ch].xfer_select;
            assign dm_auto = chan_in[ch].xfer_d &
                ~chan_in[ch].xfer_select;

            status_flag_cell u_ovf (
                .hclk     (hclk),
                .hresetn  (hresetn),
                .set_evt  (ovf_evt[ch]),
                .auto_clr (ovf_auto),
                .rd_seen  (rd_stb & sel_stat[ch]),
                .wr_seen  (wr_stb & sel_stat[ch]),
                .wr_bit   (hwdata[tsf_pkg::OVF_BIT]),
                .flag     (ovf_flag[ch])
            );

            if (tsf_pkg::UNF_CH[ch]) begin : g_unf
                status_flag_cell u_unf (
                    .hclk     (hclk),
                    .hresetn  (hresetn),
                    .set_evt  (unf_evt[ch]),
                    .auto_clr (1'b0),
                    .rd_seen  (rd_stb & sel_stat[ch]),
                    .wr_seen  (wr_stb & sel_stat[ch]),
                    .wr_bit   (hwdata[tsf_pkg::UNF_BIT]),
                    .flag     (unf_flag[ch])
                );
            end else begin : g_no_unf
                assign unf_flag[ch] = 1'b0;
            end

            if (tsf_pkg::DFL_CH[ch]) begin : g_dfl
                status_flag_cell u_dfl (
                    .hclk     (hclk),
                    .hresetn  (hresetn),
                    .set_evt  (dm_evt[ch]),
                    .auto_clr (dm_auto),
                    .rd_seen  (rd_stb & sel_stat[ch]),
                    .wr_seen  (wr_stb & sel_stat[ch]),
                    .wr_bit   (hwdata[tsf_pkg::DFL_BIT]),
                    .flag     (dm_flag[ch])
                );
            end else begin : g_no_dfl
                assign dm_flag[ch] = 1'b0;
            end

            // status word as software sees it
            assign dir_bit = tsf_pkg::DIR_CH[ch] ?
                chan_in[ch].count_up : 1'b1;
            assign stat_val[ch] = {dir_bit, 1'b1,
                                   unf_flag[ch], ovf_flag[ch],
                                   dm_flag[ch], 3'h0};
            assign rd_term[ch] =
                sel_stat[ch] ? {24'h0, stat_val[ch]} :
                sel_en[ch]   ? {24'h0, 2'h0, en_reg[ch], 3'h0} : 32'h0;

            assign irq_evt[ch*tsf_pkg::EV_W + tsf_pkg::EV_UNF] = unf_evt[ch];
            assign irq_evt[ch*tsf_pkg::EV_W + tsf_pkg::EV_OVF] = ovf_evt[ch];
            assign irq_evt[ch*tsf_pkg::EV_W + tsf_pkg::EV_DFL] = dm_evt[ch];

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    prev_reg[ch]    <= tsf_pkg::CNT_ZERO;
                    en_reg[ch]      <= '0;
                    ovf_req_reg[ch] <= 1'b0;
                    unf_req_reg[ch] <= 1'b0;
                    dm_req_reg[ch]  <= 1'b0;
                end else begin
                    prev_reg[ch] <= cur;
                    if (wr_stb && sel_en[ch]) begin
                        en_reg[ch] <= {
                            hwdata[tsf_pkg::UNF_BIT] & tsf_pkg::UNF_CH[ch],
                            hwdata[tsf_pkg::OVF_BIT],
                            hwdata[tsf_pkg::DFL_BIT] & tsf_pkg::DFL_CH[ch]};
                    end
                    ovf_req_reg[ch] <= ovf_flag[ch] &
                        en_reg[ch][tsf_pkg::EV_OVF];
                    unf_req_reg[ch] <= unf_flag[ch] &
                        en_reg[ch][tsf_pkg::EV_DFL];
                    dm_req_reg[ch]  <= dm_flag[ch] &
                        en_reg[ch][tsf_pkg::EV_UNF];
                end
            end

            // checks per channel
            property p_ovf_set;
                @(posedge hclk) disable iff (!hresetn)
                (prev_ok_reg && prev_reg[ch] == tsf_pkg::CNT_MAX &&
                 cur == tsf_pkg::CNT_ZERO) |=> ovf_flag[ch];
            endproperty
            a_ovf_set: assert property (p_ovf_set)
                else $error("overflow wrap did not set the flag");

            property p_ovf_req;
                @(posedge hclk) disable iff (!hresetn)
                ovf_req_reg[ch] == $past(ovf_flag[ch] &
                                         en_reg[ch][tsf_pkg::EV_OVF]);
            endproperty
            a_ovf_req: assert property (p_ovf_req)
                else $error("overflow request disagrees with flag and enable");

            property p_stat_read;
                @(posedge hclk) disable iff (!hresetn)
                (rd_stb && sel_stat[ch]) |=> hreadyout_reg &&
                    hrdata_reg[tsf_pkg::RSV6_BIT] &&
                    (tsf_pkg::DIR_CH[ch] ||
                     hrdata_reg[tsf_pkg::DIR_BIT]) &&
                    (tsf_pkg::UNF_CH[ch] ||
                     !hrdata_reg[tsf_pkg::UNF_BIT]) &&
                    (tsf_pkg::DFL_CH[ch] ||
                     !hrdata_reg[tsf_pkg::DFL_BIT]);
            endproperty
            a_stat_read: assert property (p_stat_read)
                else $error("reserved status bit read wrong");

            property p_dir_read;
                @(posedge hclk) disable iff (!hresetn)
                (rd_stb && sel_stat[ch] && tsf_pkg::DIR_CH[ch]) |=>
                    hrdata_reg[tsf_pkg::DIR_BIT] ==
                    $past(chan_in[ch].count_up);
            endproperty
            a_dir_read: assert property (p_dir_read)
                else $error("direction bit does not follow the counter");

            property p_dm_set;
                @(posedge hclk) disable iff (!hresetn)
                dm_evt[ch] |=> dm_flag[ch];
            endproperty
            a_dm_set: assert property (p_dm_set)
                else $error("match or capture did not set flag d");
            property p_dm_auto;
                @(posedge hclk) disable iff (!hresetn)
                (dm_auto && !dm_evt[ch]) |=> !dm_flag[ch];
            endproperty
            a_dm_auto: assert property (p_dm_auto)
                else $error("transfer start did not clear flag d");
        end
    endgenerate

    // ----------------------------------------------------------------
    // checks on the pwm channel and channel 1 underflow, and covers
    // ----------------------------------------------------------------
    property p_pwm_ovf;
        @(posedge hclk) disable iff (!hresetn)
        g_ch[tsf_pkg::PWM_CH].pwm_wrap && prev_ok_reg
            |=> ovf_flag[tsf_pkg::PWM_CH];
    endproperty
    a_pwm_ovf: assert property (p_pwm_ovf)
        else $error("pwm underflow did not set the overflow flag");

    property p_ovf_auto;
        @(posedge hclk) disable iff (!hresetn)
        (g_ch[tsf_pkg::PWM_CH].ovf_auto && !ovf_evt[tsf_pkg::PWM_CH])
            |=> !ovf_flag[tsf_pkg::PWM_CH] ##1 !ovf_req_reg[tsf_pkg::PWM_CH];
    endproperty
    a_ovf_auto: assert property (p_ovf_auto)
        else $error("transfer start did not clear channel 4 overflow");

    property p_unf_set;
        @(posedge hclk) disable iff (!hresetn)
        unf_evt[1] |=> unf_flag[1];
    endproperty
    a_unf_set: assert property (p_unf_set)
        else $error("underflow wrap did not set the flag");
    c_ovf: cover property (@(posedge hclk) ovf_evt[0]);
    c_pwm: cover property (@(posedge hclk) g_ch[4].pwm_wrap);
    c_clear: cover property (@(posedge hclk)
        rd_stb && sel_stat[0] && ovf_flag[0] ##2 wr_stb ##1 !ovf_flag[0]);
    c_irq: cover property (@(posedge hclk) irq_reg);
    // ----------------------------------------------------------------
    // read mux and interrupt status
    // ----------------------------------------------------------------
    assign rd_word = {32{req_reg.in_range}} & (
        rd_term[0] | rd_term[1] | rd_term[2] | rd_term[3] | rd_term[4] |
        (sel_irq_stat ? {17'h0, irq_stat_reg} : 32'h0) |
        (sel_irq_mask ? {17'h0, irq_mask_reg} : 32'h0));

    assign irq_w1c = (wr_stb & sel_irq_stat) ?
                     hwdata[tsf_pkg::IRQ_W-1:0] : '0;
    assign irq_stat_next = irq_evt | (irq_stat_reg & ~irq_w1c);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_ok_reg  <= 1'b0;
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            irq_reg      <= 1'b0;
        end else begin
            prev_ok_reg  <= 1'b1;
            irq_stat_reg <= irq_stat_next;
            if (wr_stb && sel_irq_mask) begin
                irq_mask_reg <= hwdata[tsf_pkg::IRQ_W-1:0];
            end
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign hrdata     = hrdata_reg;
    assign hreadyout  = hreadyout_reg;
    assign hresp      = hresp_reg;
    assign ovf_req    = ovf_req_reg;
    assign unf_req    = unf_req_reg;
    assign dmatch_req = dm_req_reg;
    assign irq        = irq_reg;

endmodule // timer_channel_status_flags

// ===== hdl/tsf_pkg.sv
// constants and types for the timer channel status flag block
package tsf_pkg;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int              NCH       = 5;
    localparam int              CW        = 16;
    localparam int              AW        = 8;
    localparam int              IRQ_W     = 15;
    localparam int              EV_W      = 3;
    localparam int              PWM_CH    = 4;

    // ----------------------------------------------------------------
    // counter values that mark a wrap
    // ----------------------------------------------------------------
    localparam logic [CW-1:0]   CNT_MAX   = 16'hffff;
    localparam logic [CW-1:0]   CNT_ZERO  = 16'h0000;
    localparam logic [CW-1:0]   CNT_ONE   = 16'h0001;

    // ----------------------------------------------------------------
    // status field positions
    // ----------------------------------------------------------------
    localparam int              DIR_BIT   = 7;
    localparam int              RSV6_BIT  = 6;
    localparam int              UNF_BIT   = 5;
    localparam int              OVF_BIT   = 4;
    localparam int              DFL_BIT   = 3;

    // event positions inside one channel slice of irq status
    localparam int              EV_UNF    = 0;
    localparam int              EV_OVF    = 1;
    localparam int              EV_DFL    = 2;

    // channels that own a field
    localparam logic [NCH-1:0]  DIR_CH    = 5'h1e;
    localparam logic [NCH-1:0]  UNF_CH    = 5'h06;
    localparam logic [NCH-1:0]  DFL_CH    = 5'h19;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [AW-1:0]   STATUS_BASE    = 8'h00;
    localparam logic [AW-1:0]   ENABLE_BASE    = 8'h20;
    localparam logic [AW-1:0]   IRQ_STATUS_OFS = 8'h40;
    localparam logic [AW-1:0]   IRQ_MASK_OFS   = 8'h44;
    localparam logic [AW-1:0]   WORD_STEP      = 8'h04;

    // ----------------------------------------------------------------
    // bus encodings and states
    // ----------------------------------------------------------------
    localparam logic [1:0]      HTRANS_NONSEQ  = 2'h2;
    localparam logic [1:0]      HRESP_OKAY     = 2'h0;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_DATA = 1'b1
    } bus_state_e;

    typedef struct packed {
        logic           write;
        logic           in_range;
        logic [AW-1:0]  addr;
    } bus_req_s;

    // one channel's view of the counter core
    typedef struct packed {
        logic [CW-1:0]  counter;
        logic [CW-1:0]  grd;
        logic           count_up;
        logic           phase_mode;
        logic           comp_pwm;
        logic           d_compare;
        logic           d_capture;
        logic           capture_stb;
        logic           xfer_ovf;
        logic           xfer_d;
        logic           xfer_select;
    } chan_in_s;

endpackage
